//--- rtl/core_mem_regs.svh
// constants for the core memory bank, port switch and multiplexer
// assumes a 25 MHz system clock; included by every design file but the interface
`ifndef CORE_MEM_REGS_SVH
`define CORE_MEM_REGS_SVH

// ==========================================================
// word and address layout (vector bit 17 is the msb, bit 0)
`define DATA_W 18
`define STORED_W 19
`define ADDR_W 18
`define ILLEGAL_BIT 17
`define BANK_MSB 16
`define BANK_LSB 13
`define PAGE_BIT 12
`define CELL_W 12
`define PAGE_WORDS 4096
`define BANK_WORDS 8192
`define BANK_COUNT 16
`define BANKS_FITTED 4
`define BLOCK_WORDS 32768
`define MAX_WORDS 131072
`define INDEX_W 15
`define NUM_PORTS 3
`define PORT_IO 0
`define PORT_CPU 1
`define PORT_AUX 2

// ==========================================================
// timing, in ns and in 40 ns clock cycles (least times round up)
`define CLK_NS 40
`define ACCESS_NS 400
`define CYCLE_NS 800
`define PARITY_CYCLE_NS 1100
`define MUX_DELAY_NS 120
`define ACCESS_CYC ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define CYCLE_CYC ((`CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define PARITY_CYC ((`PARITY_CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define MUX_CYC ((`MUX_DELAY_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 5

`endif

//--- rtl/core_mem_pkg.sv
// types shared by the core memory design files
// assumes core_mem_regs.svh supplies the widths
`default_nettype none
`include "core_mem_regs.svh"

package core_mem_pkg;
  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`STORED_W-1:0] stored_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`INDEX_W-1:0] index_t;
  typedef logic [1:0] port_idx_t;
  typedef logic [`CNT_W-1:0] count_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ROUTE = 2'b01,
    ST_MUXWAIT = 2'b10,
    ST_BANK = 2'b11
  } sw_state_t;
endpackage : core_mem_pkg

`default_nettype wire

//--- rtl/bank_link_if.sv
// link between the port switch and the bank storage
// assumes both ends share mclk
`default_nettype none

interface bank_link_if (
  input wire logic mclk
);
  logic start;
  logic write;
  logic parity_on;
  core_mem_pkg::index_t index;
  core_mem_pkg::word_t wdata;
  core_mem_pkg::word_t rdata;
  logic done;
  logic parity_err;

  modport ctrl (
    output start, output write, output parity_on, output index, output wdata,
    input rdata, input done, input parity_err
  );
  modport bank (
    input start, input write, input parity_on, input index, input wdata,
    output rdata, output done, output parity_err
  );
endinterface : bank_link_if

`default_nettype wire

//--- rtl/port_priority_switch.sv
// fixed priority pick among the three memory ports
// assumes the caller has already masked ports that must not be served
`default_nettype none
`include "core_mem_regs.svh"

module port_priority_switch (
  input wire logic [`NUM_PORTS-1:0] eligible,
  output logic any,
  output core_mem_pkg::port_idx_t pick
);
  // ==========================================================
  // io_processor beats the cpu, the cpu beats the auxiliary port
  always_comb begin
    any = |eligible;
    pick = 2'h0;
    if (eligible[`PORT_IO]) begin
      pick = 2'h0;
    end else if (eligible[`PORT_CPU]) begin
      pick = 2'h1;
    end else if (eligible[`PORT_AUX]) begin
      pick = 2'h2;
    end
  end
endmodule : port_priority_switch

`default_nettype wire

//--- rtl/core_bank_store.sv
// storage for the fitted banks with address and data buffers and parity
// assumes start is a one-cycle pulse given only while no cycle runs
`default_nettype none
`include "core_mem_regs.svh"

module core_bank_store (
  input wire logic mclk,
  input wire logic rst_n,
  bank_link_if.bank link
);
  localparam int WORDS = `BANKS_FITTED * `BANK_WORDS;

  core_mem_pkg::stored_t cells [0:WORDS-1];
  core_mem_pkg::index_t addr_buf;
  core_mem_pkg::stored_t data_buf;
  core_mem_pkg::count_t cnt;
  core_mem_pkg::count_t last;
  logic busy;
  logic is_write;
  logic par_on;
  logic done;
  logic perr;

  // the parity cycle is longer and applies to every bank at once
  assign last = par_on ? 5'(`PARITY_CYC - 1) : 5'(`CYCLE_CYC - 1);

  // ==========================================================
  // address buffer and cycle kind, caught at the start of a cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_buf <= 15'h0000;
      is_write <= 1'b0;
      par_on <= 1'b0;
    end else if (link.start) begin
      addr_buf <= link.index;
      is_write <= link.write;
      par_on <= link.parity_on;
    end
  end

  // cycle timer; one cycle in progress at a time
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 5'h00;
    end else if (link.start) begin
      busy <= 1'b1;
      cnt <= 5'h00;
    end else if (busy) begin
      cnt <= cnt + 5'h01;
      if (cnt == last) begin
        busy <= 1'b0;
      end
    end
  end

  // ==========================================================
  // data buffer: all 19 bits move at once between array and buffer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_buf <= 19'h00000;
    end else if (link.start) begin
      // with parity on, the stored bit makes the total count of ones odd; with it off, the bit is 0
      data_buf <= {link.parity_on & ~(^link.wdata), link.wdata};
    end else if (busy && !is_write && cnt == 5'(`ACCESS_CYC - 1)) begin
      data_buf <= cells[addr_buf];
    end
  end

  // restore at cycle end; a read writes back what it took out
  always_ff @(posedge mclk) begin
    if (busy && cnt == last) begin
      cells[addr_buf] <= data_buf;
    end
  end

  // ==========================================================
  // check the word as it lands in the buffer, report one cycle later
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      perr <= 1'b0;
    end else begin
      perr <= busy && !is_write && par_on && cnt == 5'(`ACCESS_CYC) &&
              ((~(^data_buf[`DATA_W-1:0])) != data_buf[`DATA_W]);
    end
  end

  // completion pulse in the cycle after the last cycle of the timer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= busy && cnt == last;
    end
  end

  assign link.rdata = data_buf[`DATA_W-1:0];
  assign link.done = done;
  assign link.parity_err = perr;
endmodule : core_bank_store

`default_nettype wire

//--- rtl/core_memory_system.sv
// core memory: port switch, multiport relocation and bank storage
// assumes every port holds req, write, addr and wdata until its grant
`default_nettype none
`include "core_mem_regs.svh"

module core_memory_system (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic parity_fitted,
  input wire logic protect_fitted,
  input wire logic mux_fitted,
  input wire logic [`NUM_PORTS-1:0] port_req,
  input wire logic [`NUM_PORTS-1:0] port_write,
  input wire logic [`NUM_PORTS-1:0][`ADDR_W-1:0] port_addr,
  input wire logic [`NUM_PORTS-1:0][`DATA_W-1:0] port_wdata,
  input wire logic [`NUM_PORTS-1:0][`BANK_MSB-`BANK_LSB:0] port_reloc,
  input wire logic parity_alarm_clr,
  output logic [`NUM_PORTS-1:0] port_grant,
  output logic [`NUM_PORTS-1:0] port_trap,
  output logic [`DATA_W-1:0] port_rdata,
  output logic parity_error,
  output logic parity_alarm
);
  core_mem_pkg::sw_state_t state;
  core_mem_pkg::port_idx_t sel;
  core_mem_pkg::port_idx_t pick;
  core_mem_pkg::addr_t cur_addr;
  core_mem_pkg::count_t mux_cnt;
  logic [`NUM_PORTS-1:0] parked;
  logic [`NUM_PORTS-1:0] eligible;
  logic [`NUM_PORTS-1:0] port_on;
  logic [`NUM_PORTS-1:0] set_park;
  logic [`NUM_PORTS-1:0] next_grant;
  logic [`NUM_PORTS-1:0] next_trap;
  logic [`BANK_MSB-`BANK_LSB:0] logical_bank;
  logic [`BANK_MSB-`BANK_LSB:0] phys_bank;
  logic any_req;
  logic illegal;
  logic absent;
  logic start;

  bank_link_if link (.mclk(mclk));

  // ==========================================================
  // port eligibility
  // the auxiliary port only exists with the multiplexer fitted
  assign port_on = {mux_fitted, 1'b1, 1'b1};

  // a parked port is either answered or hung on a bad address; it is
  // skipped so a hung requester never locks the other out of memory
  genvar p;
  generate
    for (p = 0; p < `NUM_PORTS; p++) begin : g_port
      assign eligible[p] = port_req[p] && port_on[p] && !parked[p];

      // park on grant, trap or hang; leave once the request drops
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          parked[p] <= 1'b0;
        end else if (set_park[p]) begin
          parked[p] <= 1'b1;
        end else if (!port_req[p]) begin
          parked[p] <= 1'b0;
        end
      end
    end
  endgenerate

  port_priority_switch u_switch (
    .eligible(eligible),
    .any(any_req),
    .pick(pick)
  );

  // ==========================================================
  // address decode of the latched request
  // bank field holds 4 bits so up to 16 banks decode
  assign logical_bank = cur_addr[`BANK_MSB:`BANK_LSB];
  // relocation is modulo 16 so bank 0 of one port may be the top of another
  assign phys_bank = mux_fitted ? logical_bank + port_reloc[sel] : logical_bank;
  assign illegal = cur_addr[`ILLEGAL_BIT];
  // beyond the fitted 32K only what the relocation lands in range answers
  assign absent = phys_bank >= 4'(`BANKS_FITTED);

  // ==========================================================
  // port switch state machine: one bank cycle in flight at a time
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= core_mem_pkg::ST_IDLE;
    end else begin
      case (state)
        core_mem_pkg::ST_IDLE: begin
          if (any_req) begin
            state <= core_mem_pkg::ST_ROUTE;
          end
        end
        core_mem_pkg::ST_ROUTE: begin
          if (illegal || absent) begin
            state <= core_mem_pkg::ST_IDLE;
          end else if (mux_fitted) begin
            state <= core_mem_pkg::ST_MUXWAIT;
          end else begin
            state <= core_mem_pkg::ST_BANK;
          end
        end
        core_mem_pkg::ST_MUXWAIT: begin
          if (mux_cnt == 5'(`MUX_CYC - 1)) begin
            state <= core_mem_pkg::ST_BANK;
          end
        end
        core_mem_pkg::ST_BANK: begin
          if (link.done) begin
            state <= core_mem_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= core_mem_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // winner and its address are held for the whole cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel <= 2'h0;
      cur_addr <= 18'h00000;
    end else if (state == core_mem_pkg::ST_IDLE && any_req) begin
      sel <= pick;
      cur_addr <= port_addr[pick];
    end
  end

  // extra passage delay through the multiplexer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mux_cnt <= 5'h00;
    end else if (state == core_mem_pkg::ST_MUXWAIT) begin
      mux_cnt <= mux_cnt + 5'h01;
    end else begin
      mux_cnt <= 5'h00;
    end
  end

  // ==========================================================
  // bank start: one pulse when routing ends, or after the mux delay
  always_comb begin
    start = 1'b0;
    if (state == core_mem_pkg::ST_ROUTE && !illegal && !absent && !mux_fitted) begin
      start = 1'b1;
    end else if (state == core_mem_pkg::ST_MUXWAIT && mux_cnt == 5'(`MUX_CYC - 1)) begin
      start = 1'b1;
    end
  end

  assign link.start = start;
  assign link.write = port_write[sel];
  assign link.wdata = port_wdata[sel];
  assign link.parity_on = parity_fitted;
  // two fitted-bank bits, then page bit, then 12 cell bits
  assign link.index = {phys_bank[1:0], cur_addr[`PAGE_BIT:0]};

  core_bank_store u_store (
    .mclk(mclk),
    .rst_n(rst_n),
    .link(link)
  );

  // ==========================================================
  // answers: grant on completion, trap on a protected illegal (bit 17) address
  always_comb begin
    next_grant = 3'h0;
    next_trap = 3'h0;
    set_park = 3'h0;
    if (state == core_mem_pkg::ST_BANK && link.done) begin
      next_grant[sel] = 1'b1;
      set_park[sel] = 1'b1;
    end else if (state == core_mem_pkg::ST_ROUTE && (illegal || absent)) begin
      // without protect the port just hangs with no answer at all
      next_trap[sel] = illegal && protect_fitted;
      set_park[sel] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port_grant <= 3'h0;
      port_trap <= 3'h0;
    end else begin
      port_grant <= next_grant;
      port_trap <= next_trap;
    end
  end

  // read data crosses to the bus as one 18-bit word with its grant
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port_rdata <= 18'h00000;
    end else if (state == core_mem_pkg::ST_BANK && link.done) begin
      port_rdata <= link.rdata;
    end
  end

  // ==========================================================
  // parity alarm: a new error wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      parity_error <= 1'b0;
      parity_alarm <= 1'b0;
    end else begin
      parity_error <= link.parity_err;
      if (link.parity_err) begin
        parity_alarm <= 1'b1;
      end else if (parity_alarm_clr) begin
        parity_alarm <= 1'b0;
      end
    end
  end
endmodule : core_memory_system

`default_nettype wire

//--- testbench/core_mem_assertions.sv
// checker for core_memory_system: grants, traps, cycle spacing, parity alarm
// assumes it is bound to the design top and sees only that module's ports
`default_nettype none
`include "core_mem_regs.svh"

module core_mem_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic parity_fitted,
  input wire logic protect_fitted,
  input wire logic [`NUM_PORTS-1:0] port_req,
  input wire logic [`NUM_PORTS-1:0][`ADDR_W-1:0] port_addr,
  input wire logic parity_alarm_clr,
  input wire logic [`NUM_PORTS-1:0] port_grant,
  input wire logic [`NUM_PORTS-1:0] port_trap,
  input wire logic parity_error,
  input wire logic parity_alarm
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // cycles since the last grant; saturates so a long idle never wraps
  logic [5:0] gap;
  always_ff @(posedge mclk) begin
    if (!rst_n || |port_grant) begin
      gap <= 6'h00;
    end else if (gap != 6'h3F) begin
      gap <= gap + 6'h01;
    end
  end
  // ==========================================================
  // both processors ask at the same edge
  sequence both_rise;
    $rose(port_req[0]) && $rose(port_req[1]);
  endsequence
  sequence io_served;
    ##[1:60] port_grant[0];
  endsequence
  a_io_first: assert property (both_rise |-> (!port_grant[1]) throughout io_served)
    else $error("cpu served before io processor");
  a_one_grant: assert property ($onehot0(port_grant))
    else $error("two grants in one cycle");
  a_grant_has_req: assert property ((port_grant & ~$past(port_req)) == 3'h0)
    else $error("grant without a standing request");
  a_cycle_gap: assert property (|port_grant |-> gap >= (parity_fitted ? 6'h1B : 6'h13))
    else $error("bank cycles closer than a full cycle");
  a_illegal_silent: assert property (!(|(port_grant &
    {port_addr[2][17], port_addr[1][17], port_addr[0][17]})))
    else $error("illegal address answered");
  a_trap_protect: assert property (|port_trap |-> protect_fitted)
    else $error("trap without memory protect");
  a_trap_delay: assert property (port_trap[1] |->
    $past(port_req[1], 2) && $past(port_addr[1][17], 2))
    else $error("trap not two cycles after illegal request");
  a_alarm_set: assert property (parity_error |-> parity_alarm)
    else $error("parity error did not raise alarm");
  a_alarm_hold: assert property (parity_alarm && !parity_alarm_clr |=> parity_alarm)
    else $error("parity alarm dropped without clear");
  a_no_parity_err: assert property (!parity_fitted |-> !parity_error)
    else $error("parity error with parity absent");
endmodule : core_mem_assertions

bind core_memory_system core_mem_assertions core_mem_assertions_inst (
  .mclk(mclk), .rst_n(rst_n), .parity_fitted(parity_fitted),
  .protect_fitted(protect_fitted), .port_req(port_req), .port_addr(port_addr),
  .parity_alarm_clr(parity_alarm_clr), .port_grant(port_grant), .port_trap(port_trap),
  .parity_error(parity_error), .parity_alarm(parity_alarm)
);

`default_nettype wire

//--- testbench/proc_ports_model.sv
// behavioural model of the three requesters on the memory bus
// assumes the bench calls post and drop just after a falling edge
`default_nettype none
`include "core_mem_regs.svh"

module proc_ports_model (
  input wire logic mclk,
  input wire logic [`NUM_PORTS-1:0] port_grant,
  input wire logic [`NUM_PORTS-1:0] port_trap,
  output logic [`NUM_PORTS-1:0] port_req,
  output logic [`NUM_PORTS-1:0] port_write,
  output logic [`NUM_PORTS-1:0][`ADDR_W-1:0] port_addr,
  output logic [`NUM_PORTS-1:0][`DATA_W-1:0] port_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`NUM_PORTS-1:0] answered = '0;
  initial begin
    port_req = '0;
    port_write = '0;
    port_addr = '0;
    port_wdata = '0;
  end
  // ==========================================================
  // request, address and data stand together until answered
  task automatic post(input int p, input logic w, input core_mem_pkg::addr_t a,
                      input core_mem_pkg::word_t d);
    port_write[p] = w;
    port_addr[p] = a;
    port_wdata[p] = d;
    port_req[p] = 1'b1;
  endtask : post
  // released lines show inverted values, so stale data cannot pass for held data
  task automatic drop(input int p);
    port_req[p] = 1'b0;
    port_addr[p] = ~port_addr[p];
    port_wdata[p] = ~port_wdata[p];
  endtask : drop
  // the answer is taken at the rising edge, released only after it
  always @(posedge mclk) answered <= port_grant | port_trap;
  always @(negedge mclk) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (answered[p] && port_req[p]) drop(p);
    end
  end
endmodule : proc_ports_model

`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for core_memory_system
// assumes proc_ports_model drives the ports and the checker is bound
`default_nettype none
`include "core_mem_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int port; logic trap; logic rd; core_mem_pkg::word_t data;} note_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic parity_fitted = 1'b0;
  logic protect_fitted = 1'b0;
  logic mux_fitted = 1'b0;
  logic parity_alarm_clr = 1'b0;
  logic [`NUM_PORTS-1:0][3:0] port_reloc = '0;
  logic [`NUM_PORTS-1:0] port_req, port_write, port_grant, port_trap;
  logic [`NUM_PORTS-1:0][`ADDR_W-1:0] port_addr;
  logic [`NUM_PORTS-1:0][`DATA_W-1:0] port_wdata;
  core_mem_pkg::word_t port_rdata;
  logic parity_error, parity_alarm;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  note_t notes[$];
  core_mem_pkg::word_t mem[int];
  always #20 mclk = ~mclk;

  core_memory_system core_memory_system_inst (
    .mclk(mclk), .rst_n(rst_n), .parity_fitted(parity_fitted),
    .protect_fitted(protect_fitted), .mux_fitted(mux_fitted), .port_req(port_req),
    .port_write(port_write), .port_addr(port_addr), .port_wdata(port_wdata),
    .port_reloc(port_reloc), .parity_alarm_clr(parity_alarm_clr),
    .port_grant(port_grant), .port_trap(port_trap), .port_rdata(port_rdata),
    .parity_error(parity_error), .parity_alarm(parity_alarm));
  proc_ports_model proc_ports_model_inst (
    .mclk(mclk), .port_grant(port_grant), .port_trap(port_trap), .port_req(port_req),
    .port_write(port_write), .port_addr(port_addr), .port_wdata(port_wdata));

  // ==========================================================
  task automatic check_word(input string what, input core_mem_pkg::word_t exp,
                            input core_mem_pkg::word_t got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_flags(input string what, input logic [2:0] exp, input logic [2:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flags
  task automatic stop_test();
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // the whole run needs about 6000 cycles; a hang is cut off well beyond
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // ==========================================================
  // note the expected answer, then hand the request to the model
  task automatic xfer(input int p, input logic w, input core_mem_pkg::addr_t a,
                      input core_mem_pkg::word_t d);
    int key;
    key = {a[16:13] + (mux_fitted ? port_reloc[p] : 4'h0), a[12:0]};
    if (w) mem[key] = d;
    notes.push_back('{p, 1'b0, !w, w ? d : mem[key]});
    proc_ports_model_inst.post(p, w, a, d);
  endtask : xfer
  // bounded wait for the requester to let go, plus one idle cycle
  task automatic settle(input int p);
    for (int k = 0; k < 100 && port_req[p] === 1'b1; k++) @(negedge mclk);
    // a request still standing here means the limit ran out: count it
    check_flags("released", 3'h0, {2'h0, port_req[p]});
    @(negedge mclk);
  endtask : settle
  // answers are judged at the falling edge, once registered outputs settled
  always @(negedge mclk) begin : watch
    note_t n;
    if (|(port_grant | port_trap)) begin
      n = notes.size() > 0 ? notes.pop_front() : note_t'{3, 1'b0, 1'b0, 18'h00000};
      check_flags("answer", 3'h1 << n.port, n.trap ? port_trap : port_grant);
      check_flags("other answer", 3'h0, n.trap ? port_grant : port_trap);
      if (n.rd) check_word("read data", n.data, port_rdata);
    end
  end
  // ==========================================================
  initial begin : main
    core_mem_pkg::addr_t a;
    core_mem_pkg::word_t d;
    void'($urandom(89872));
    repeat (20) @(negedge mclk);
    check_flags("reset outputs", 3'h0, {parity_error, parity_alarm, |port_grant});
    rst_n = 1'b1;
    @(negedge mclk);
    // random words, both pages and all fitted banks, across both processors
    for (int pf = 0; pf < 2; pf++) begin
      parity_fitted = pf[0];
      for (int i = 0; i < 25; i++) begin
        a = {3'h0, 15'($urandom)};
        d = 18'($urandom);
        for (int k = 0; k < 4; k++) begin
          xfer(k % 2, k < 2, k[0] ? a ^ 18'h01000 : a, k[0] ? ~d : d);
          settle(k % 2);
        end
      end
    end
    check_flags("clean alarm", 3'h0, {2'h0, parity_alarm});
    // lone request latency: plain, with parity, through the multiplexer
    for (int c = 0; c < 3; c++) begin
      parity_fitted = (c == 1);
      mux_fitted = (c == 2);
      xfer(1, 1'b1, 18'h00010, 18'h2AAAA);
      repeat (22 + (c == 1 ? 8 : 0) + (c == 2 ? 3 : 0)) @(negedge mclk);
      check_flags("early grant", 3'h0, port_grant);
      @(negedge mclk);
      check_flags("timed grant", 3'h2, port_grant);
      settle(1);
    end
    // relocated port 2 writes the bank that port 0 sees as bank 3
    port_reloc[2] = 4'h3;
    xfer(2, 1'b1, 18'h00020, 18'h15555);
    settle(2);
    xfer(0, 1'b0, 18'h06020, 18'h00000);
    settle(0);
    // simultaneous requests: io processor first
    mux_fitted = 1'b0;
    parity_fitted = 1'b0;
    xfer(0, 1'b0, 18'h00010, 18'h00000);
    xfer(1, 1'b0, 18'h00010, 18'h00000);
    settle(0);
    settle(1);
    // words stored without parity bit: odd weight reads clean, even weight alarms
    for (int k = 0; k < 4; k++) begin
      parity_fitted = (k > 1);
      xfer(1, k < 2, (k == 1 || k == 2) ? 18'h00101 : 18'h00100, k == 1 ? 18'h00001 : 18'h00003);
      settle(1);
      if (k > 1) check_flags("alarm", {2'h0, k == 3}, {2'h0, parity_alarm});
    end
    parity_alarm_clr = 1'b1;
    @(negedge mclk);
    parity_alarm_clr = 1'b0;
    @(negedge mclk);
    check_flags("cleared alarm", 3'h0, {2'h0, parity_alarm});
    // illegal address: trapped with protect, silent without it
    protect_fitted = 1'b1;
    notes.push_back('{1, 1'b1, 1'b0, 18'h00000});
    proc_ports_model_inst.post(1, 1'b0, 18'h20000, 18'h00000);
    settle(1);
    // a missing bank hangs even with protect; only bit 17 addresses trap
    proc_ports_model_inst.post(1, 1'b0, 18'h0E000, 18'h00000);
    repeat (60) @(negedge mclk);
    proc_ports_model_inst.drop(1);
    @(negedge mclk);
    protect_fitted = 1'b0;
    proc_ports_model_inst.post(1, 1'b0, 18'h3FFFF, 18'h00000);
    repeat (60) @(negedge mclk);
    proc_ports_model_inst.drop(1);
    repeat (3) @(negedge mclk);
    check_word("unanswered", 18'h00000, 18'(notes.size()));
    stop_test();
  end
endmodule : tb

`default_nettype wire
